// file: include/pcg_consts.vh
/*
 pcg_consts.vh: register offsets, field positions, reset values and timing counts for the clock control block.
 Assumes an APB slave with 32-bit data and word aligned registers.
*/
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH
`define PCG_OFF_RAW_STATUS 12'h050
`define PCG_OFF_MASK 12'h054
`define PCG_OFF_MASKED 12'h058
`define PCG_OFF_RUN_CFG 12'h060
`define PCG_OFF_RUN_CFG_EXT 12'h070
`define PCG_OFF_RUN_GATE 12'h100
`define PCG_OFF_SLEEP_GATE 12'h110
`define PCG_OFF_DEEP_GATE 12'h120
`define PCG_OFF_DEEP_CLK 12'h144
`define PCG_OFF_DEBUG 12'h200
`define PCG_RST_RUN_CFG 32'h0780_3ad1
`define PCG_RST_RUN_CFG_EXT 32'h0780_2810
`define PCG_RST_GATE 32'h0000_0040
`define PCG_RST_DEEP_CLK 32'h0780_0000
`define PCG_RUN_BYPASS 11
`define PCG_RUN_PLL_POWER_DOWN_BIT_BIT 13
`define PCG_RUN_AUTO_GATE 27
`define PCG_RUN_CRYSTAL_SELECT_FIELD_LO 6
`define PCG_RUN_CRYSTAL_SELECT_FIELD_HI 9
`define PCG_RUN_SYSTEM_DIVIDER_FIELD_LO 23
`define PCG_RUN_SYSTEM_DIVIDER_FIELD_HI 26
`define PCG_RUN_OSC_LO 4
`define PCG_RUN_OSC_HI 5
`define PCG_EXT_USE 31
`define PCG_EXT_SYSTEM_DIVIDER_FIELD_LO 23
`define PCG_EXT_SYSTEM_DIVIDER_FIELD_HI 28
`define PCG_DS_DIV_LO 23
`define PCG_DS_DIV_HI 28
`define PCG_DS_OSC_LO 4
`define PCG_DS_OSC_HI 6
`define PCG_LOCK_BIT 6
`define PCG_RELOCK_COUNT 16'h1200
`endif

// file: rtl/pcg_clock_ctrl.v
/*
 pcg_clock_ctrl.v: PLL relock timing, system clock source selection, run/sleep/deep-sleep clock gating.
 Assumes an APB master on clk, a main oscillator tick from another domain, and core sleep signals on clk.
*/
// What this block does
// [RL1] pll unusable until relock interval elapses
// [RL2] crystal field change starts relock, same value not
// [RL3] pll power-up starts relock
// [RL4] down counter on oscillator ticks, loads 0x1200
// [RL5] pll source blocked until counter expires
// [RL6] enable plus select waits, then switches
// [RL7] lock raw status bit and maskable interrupt
// [RL8] software keeps stable clock before selecting pll
// [RL9] run mode uses run gating registers
// [RL10] sleep stops core and memory clocks
// [RL11] sleep gates by sleep regs when auto
// [RL12] sleep keeps run source and frequency
// [RL13] interrupt wakes; sleep only by code request
// [RL14] software sets deep enable then waits
// [RL15] deep-sleep gates by deep regs when auto
// [RL16] deep-sleep source main or chosen internal
// [RL17] internal choice powers main oscillator down
// [RL18] running pll powered down, divider overridden
// [RL19] wake restores source before reenabling clocks
// [RL20] early peripheral access with debug faults
// [RL21] software delays at wake routine start
// [RL22] debug port off at reset, serial enable
// [RL23] clearing power-down bit enables pll
// [RL24] new change reloads counter, clears lock
`timescale 1ns/10ps
`include "pcg_consts.vh"
module pcg_clock_ctrl #(
	parameter GATE_W = 32,
	parameter WAKE_SETTLE = 8
) (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire mosc_tick,
	input wire wfi_req,
	input wire deep_sleep_en,
	input wire wake_irq,
	input wire debug_enable_req,
	input wire periph_access,
	output reg pll_power_down,
	output reg pll_lock_irq,
	output reg use_pll,
	output reg [1:0] sys_osc_sel,
	output reg [5:0] sys_div,
	output reg main_osc_off,
	output reg [2:0] int_osc_on,
	output reg core_clk_en,
	output reg [GATE_W-1:0] periph_clk_en,
	output reg debug_enabled,
	output reg hard_fault
);
	localparam ST_RUN = 4'b0001;
	localparam ST_SLEEP = 4'b0010;
	localparam ST_DEEP = 4'b0100;
	localparam ST_WAKE = 4'b1000;

	reg [31:0] run_clock_config;
	reg [31:0] run_clock_config_ext;
	reg [GATE_W-1:0] run_gating_regs;
	reg [GATE_W-1:0] sleep_gating_regs;
	reg [GATE_W-1:0] deepsleep_gating_regs;
	reg [31:0] deepsleep_clock_config;
	reg lock_mask;
	reg pll_lock_raw_status;
	reg [15:0] relock_cnt;
	reg relock_busy;
	reg tick_s1, tick_s2, tick_s3;
	reg [3:0] state;
	reg [3:0] wake_cnt;
	reg saved_use_pll;
	reg [1:0] saved_osc;
	reg [5:0] saved_div;
	reg [31:0] rd;
	wire wr = psel & penable & pwrite;
	wire rd_en = psel & penable & ~pwrite;
	wire ext_on = run_clock_config_ext[`PCG_EXT_USE];
	wire auto_gate = run_clock_config[`PCG_RUN_AUTO_GATE];
	wire tick_edge = tick_s2 & ~tick_s3;
	wire hit_run_cfg = wr & (paddr == `PCG_OFF_RUN_CFG);
	wire hit_ext = wr & (paddr == `PCG_OFF_RUN_CFG_EXT);
	wire pd_now = ext_on ? run_clock_config_ext[`PCG_RUN_PLL_POWER_DOWN_BIT_BIT] : run_clock_config[`PCG_RUN_PLL_POWER_DOWN_BIT_BIT];
	wire bypass_now = ext_on ? run_clock_config_ext[`PCG_RUN_BYPASS] : run_clock_config[`PCG_RUN_BYPASS];
	wire crystal_select_field_change = hit_run_cfg &
		(pwdata[`PCG_RUN_CRYSTAL_SELECT_FIELD_HI:`PCG_RUN_CRYSTAL_SELECT_FIELD_LO] != run_clock_config[`PCG_RUN_CRYSTAL_SELECT_FIELD_HI:`PCG_RUN_CRYSTAL_SELECT_FIELD_LO]); // see [RL2]
	wire pd_clear = (hit_run_cfg & ~ext_on & run_clock_config[`PCG_RUN_PLL_POWER_DOWN_BIT_BIT] & ~pwdata[`PCG_RUN_PLL_POWER_DOWN_BIT_BIT]) |
		(hit_ext & run_clock_config_ext[`PCG_RUN_PLL_POWER_DOWN_BIT_BIT] & ~pwdata[`PCG_RUN_PLL_POWER_DOWN_BIT_BIT]); // see [RL3] [RL23]
	// a pll powered down for deep sleep comes back up on wake, so it has to relock before use
	wire relock_start = crystal_select_field_change | pd_clear | ((state == ST_DEEP) & wake_irq & saved_use_pll); // see [RL3]
	wire ds_internal = deepsleep_clock_config[`PCG_DS_OSC_HI:`PCG_DS_OSC_LO] != 3'b000;

	// pick the active divider width: extended field reaches /64, base field /16
	function [5:0] active_div;
		input ext;
		input [31:0] base;
		input [31:0] extr;
		begin
			if (ext)
				active_div = extr[`PCG_EXT_SYSTEM_DIVIDER_FIELD_HI:`PCG_EXT_SYSTEM_DIVIDER_FIELD_LO];
			else
				active_div = {2'b00, base[`PCG_RUN_SYSTEM_DIVIDER_FIELD_HI:`PCG_RUN_SYSTEM_DIVIDER_FIELD_LO]};
		end
	endfunction

	// oscillator tick crosses from the main oscillator domain
	always @(posedge clk) begin
		if (rst) begin
			tick_s1 <= 1'b0;
			tick_s2 <= 1'b0;
			tick_s3 <= 1'b0;
		end else begin
			tick_s1 <= mosc_tick;
			tick_s2 <= tick_s1;
			tick_s3 <= tick_s2;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			run_clock_config <= `PCG_RST_RUN_CFG;
			run_clock_config_ext <= `PCG_RST_RUN_CFG_EXT;
			run_gating_regs <= `PCG_RST_GATE;
			sleep_gating_regs <= `PCG_RST_GATE;
			deepsleep_gating_regs <= `PCG_RST_GATE;
			deepsleep_clock_config <= `PCG_RST_DEEP_CLK;
			lock_mask <= 1'b0;
		end else if (wr) begin
			if (paddr == `PCG_OFF_RUN_CFG)
				run_clock_config <= pwdata;
			else if (paddr == `PCG_OFF_RUN_CFG_EXT)
				run_clock_config_ext <= pwdata;
			else if (paddr == `PCG_OFF_RUN_GATE)
				run_gating_regs <= pwdata[GATE_W-1:0];
			else if (paddr == `PCG_OFF_SLEEP_GATE)
				sleep_gating_regs <= pwdata[GATE_W-1:0];
			else if (paddr == `PCG_OFF_DEEP_GATE)
				deepsleep_gating_regs <= pwdata[GATE_W-1:0];
			else if (paddr == `PCG_OFF_DEEP_CLK)
				deepsleep_clock_config <= pwdata;
			else if (paddr == `PCG_OFF_MASK)
				lock_mask <= pwdata[`PCG_LOCK_BIT];
		end
	end

	// relock counter; a restart mid-count reloads and drops lock
	always @(posedge clk) begin
		if (rst) begin
			relock_cnt <= 16'h0000;
			relock_busy <= 1'b0;
			pll_lock_raw_status <= 1'b0;
		end else if (relock_start) begin
			relock_cnt <= `PCG_RELOCK_COUNT; // see [RL4] [RL24]
			relock_busy <= 1'b1;
			pll_lock_raw_status <= 1'b0; // see [RL1] [RL24]
		end else if (relock_busy & tick_edge) begin
			if (relock_cnt == 16'h0001) begin
				relock_busy <= 1'b0;
				pll_lock_raw_status <= 1'b1; // see [RL7]
			end
			relock_cnt <= relock_cnt - 16'h0001; // see [RL4]
		end else if (pd_now) begin
			pll_lock_raw_status <= 1'b0;
		end
	end

	// clearing the masked status via write-one is the only clear; a new lock event wins
	reg lock_seen;
	wire lock_rise = relock_busy & tick_edge & (relock_cnt == 16'h0001);
	always @(posedge clk) begin
		if (rst)
			lock_seen <= 1'b0;
		else if (lock_rise)
			lock_seen <= 1'b1;
		else if (wr & (paddr == `PCG_OFF_MASKED) & pwdata[`PCG_LOCK_BIT])
			lock_seen <= 1'b0;
	end

	always @* begin
		rd = 32'h0000_0000;
		if (paddr == `PCG_OFF_RAW_STATUS)
			rd[`PCG_LOCK_BIT] = pll_lock_raw_status; // see [RL7]
		else if (paddr == `PCG_OFF_MASK)
			rd[`PCG_LOCK_BIT] = lock_mask;
		else if (paddr == `PCG_OFF_MASKED)
			rd[`PCG_LOCK_BIT] = lock_seen & lock_mask;
		else if (paddr == `PCG_OFF_RUN_CFG)
			rd = run_clock_config;
		else if (paddr == `PCG_OFF_RUN_CFG_EXT)
			rd = run_clock_config_ext;
		else if (paddr == `PCG_OFF_RUN_GATE)
			rd[GATE_W-1:0] = run_gating_regs;
		else if (paddr == `PCG_OFF_SLEEP_GATE)
			rd[GATE_W-1:0] = sleep_gating_regs;
		else if (paddr == `PCG_OFF_DEEP_GATE)
			rd[GATE_W-1:0] = deepsleep_gating_regs;
		else if (paddr == `PCG_OFF_DEEP_CLK)
			rd = deepsleep_clock_config;
		else if (paddr == `PCG_OFF_DEBUG)
			rd[0] = debug_enabled;
	end

	wire known_addr = (paddr == `PCG_OFF_RAW_STATUS) | (paddr == `PCG_OFF_MASK) | (paddr == `PCG_OFF_MASKED) |
		(paddr == `PCG_OFF_RUN_CFG) | (paddr == `PCG_OFF_RUN_CFG_EXT) | (paddr == `PCG_OFF_RUN_GATE) |
		(paddr == `PCG_OFF_SLEEP_GATE) | (paddr == `PCG_OFF_DEEP_GATE) | (paddr == `PCG_OFF_DEEP_CLK) |
		(paddr == `PCG_OFF_DEBUG);

	// zero wait state slave: pready is registered high during the access phase
	always @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~known_addr;
			prdata <= (psel & ~penable & ~pwrite) ? rd : 32'h0000_0000;
		end
	end

	// power mode sequencer
	always @(posedge clk) begin
		if (rst) begin
			state <= ST_RUN;
			wake_cnt <= 4'h0;
			saved_use_pll <= 1'b0;
			saved_osc <= 2'b00;
			saved_div <= 6'h00;
		end else begin
			case (state)
				ST_RUN: begin
					if (wfi_req & deep_sleep_en) begin
						state <= ST_DEEP; // see [RL13]
						saved_use_pll <= use_pll;
						saved_osc <= sys_osc_sel;
						saved_div <= sys_div;
					end else if (wfi_req)
						state <= ST_SLEEP; // see [RL10] [RL13]
				end
				ST_SLEEP: begin
					if (wake_irq)
						state <= ST_RUN; // see [RL13]
				end
				ST_DEEP: begin
					if (wake_irq) begin
						state <= ST_WAKE; // see [RL19]
						wake_cnt <= WAKE_SETTLE[3:0];
					end
				end
				ST_WAKE: begin
					if (wake_cnt == 4'h0)
						state <= ST_RUN;
					else
						wake_cnt <= wake_cnt - 4'h1;
				end
				default: state <= ST_RUN;
			endcase
		end
	end

	// clock outputs, all registered
	always @(posedge clk) begin
		if (rst) begin
			use_pll <= 1'b0;
			sys_osc_sel <= 2'b00;
			sys_div <= 6'h0f;
			pll_power_down <= 1'b1;
			main_osc_off <= 1'b0;
			int_osc_on <= 3'b000;
			core_clk_en <= 1'b1;
			periph_clk_en <= `PCG_RST_GATE;
			pll_lock_irq <= 1'b0;
		end else begin
			pll_lock_irq <= lock_seen & lock_mask; // see [RL7]
			if (state == ST_DEEP) begin
				core_clk_en <= 1'b0;
				periph_clk_en <= auto_gate ? deepsleep_gating_regs : run_gating_regs; // see [RL15]
				use_pll <= 1'b0;
				sys_osc_sel <= 2'b00; // see [RL16]
				main_osc_off <= ds_internal; // see [RL17]
				int_osc_on <= deepsleep_clock_config[`PCG_DS_OSC_HI:`PCG_DS_OSC_LO]; // see [RL17]
				if (saved_use_pll) begin
					pll_power_down <= 1'b1; // see [RL18]
					sys_div <= ext_on ? deepsleep_clock_config[`PCG_DS_DIV_HI:`PCG_DS_DIV_LO] :
						{2'b00, deepsleep_clock_config[`PCG_DS_DIV_LO+3:`PCG_DS_DIV_LO]}; // see [RL18]
				end
			end else if (state == ST_WAKE) begin
				// source and divider first, core only after settling; peripherals keep their deep-sleep gating until then
				use_pll <= saved_use_pll & pll_lock_raw_status; // see [RL19] [RL5]
				sys_osc_sel <= saved_osc;
				sys_div <= saved_div; // see [RL19]
				main_osc_off <= 1'b0;
				int_osc_on <= 3'b000;
				pll_power_down <= pd_now;
				core_clk_en <= 1'b0;
			end else begin
				pll_power_down <= pd_now; // see [RL23]
				main_osc_off <= 1'b0;
				int_osc_on <= 3'b000;
				sys_osc_sel <= ext_on ? run_clock_config_ext[`PCG_RUN_OSC_HI:`PCG_RUN_OSC_LO] :
					run_clock_config[`PCG_RUN_OSC_HI:`PCG_RUN_OSC_LO]; // see [RL12]
				sys_div <= active_div(ext_on, run_clock_config, run_clock_config_ext);
				// the pll is only taken once locked; held on oscillator meanwhile
				use_pll <= ~bypass_now & ~pd_now & pll_lock_raw_status & ~relock_busy; // see [RL1] [RL5] [RL6] [RL9]
				if (state == ST_SLEEP) begin
					core_clk_en <= 1'b0; // see [RL10]
					periph_clk_en <= auto_gate ? sleep_gating_regs : run_gating_regs; // see [RL11]
				end else begin
					core_clk_en <= 1'b1;
					periph_clk_en <= run_gating_regs; // see [RL9]
				end
			end
		end
	end

	// debug port: off after reset, only the serial debug side enables it
	always @(posedge clk) begin
		if (rst) begin
			debug_enabled <= 1'b0;
			hard_fault <= 1'b0;
		end else begin
			if (debug_enable_req)
				debug_enabled <= 1'b1; // see [RL22]
			hard_fault <= debug_enabled & periph_access & (state == ST_WAKE); // see [RL20]
		end
	end
endmodule // pcg_clock_ctrl

// file: testbench/pcg_clock_ctrl_props.sv
/* pcg_clock_ctrl_props.sv: port checks of the clock control block.
 Assumes a bind into pcg_clock_ctrl, one clk domain. */
`timescale 1ns/10ps
`include "pcg_consts.vh"
module pcg_chk (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire wfi_req,
	input wire deep_sleep_en,
	input wire debug_enable_req,
	input wire periph_access,
	input wire pll_power_down,
	input wire use_pll,
	input wire [5:0] sys_div,
	input wire main_osc_off,
	input wire core_clk_en,
	input wire debug_enabled,
	input wire hard_fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_ans; psel && !penable |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no apb answer");
	property p_relock; psel && penable && pready && pwrite && paddr == `PCG_OFF_RUN_CFG
		&& !pwdata[`PCG_RUN_PLL_POWER_DOWN_BIT_BIT] && pll_power_down && core_clk_en |=> !use_pll [*8]; endproperty
	a_relock: assert property (p_relock) else $error("pll used during relock");
	property p_powered; $rose(use_pll) |-> !pll_power_down; endproperty
	a_powered: assert property (p_powered) else $error("pll used while down");
	property p_req; $fell(core_clk_en) |-> $past(wfi_req) || $past(wfi_req, 2); endproperty
	a_req: assert property (p_req) else $error("sleep without request");
	property p_deep; wfi_req && deep_sleep_en && use_pll && core_clk_en |-> ##[1:4] pll_power_down && !use_pll;
	endproperty
	a_deep: assert property (p_deep) else $error("pll kept in deep sleep");
	property p_restore; $rose(core_clk_en) |-> $stable(sys_div); endproperty
	a_restore: assert property (p_restore) else $error("divider late on wake");
	property p_osc; main_osc_off |-> !core_clk_en; endproperty
	a_osc: assert property (p_osc) else $error("oscillator off in run");
	property p_dbg; $rose(debug_enabled) |-> $past(debug_enable_req); endproperty
	a_dbg: assert property (p_dbg) else $error("debug enabled unasked");
	property p_fault; hard_fault |-> $past(debug_enabled) && $past(periph_access); endproperty
	a_fault: assert property (p_fault) else $error("fault without debug access");
endmodule // pcg_chk
bind pcg_clock_ctrl pcg_chk u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .wfi_req(wfi_req), .deep_sleep_en(deep_sleep_en),
	.debug_enable_req(debug_enable_req), .periph_access(periph_access), .pll_power_down(pll_power_down),
	.use_pll(use_pll), .sys_div(sys_div), .main_osc_off(main_osc_off), .core_clk_en(core_clk_en),
	.debug_enabled(debug_enabled), .hard_fault(hard_fault));

// file: testbench/pcg_core_model.sv
/* pcg_core_model.sv: core and main oscillator facing the clock control block.
 Assumes tasks are called just after a rising clk edge. */
`timescale 1ns/10ps
module pcg_core_model (
	input wire clk,
	output reg mosc_tick,
	output reg wfi_req,
	output reg deep_sleep_en,
	output reg wake_irq,
	output reg periph_access
);
	reg ph = 1'b0;
	initial {mosc_tick, wfi_req, deep_sleep_en, wake_irq, periph_access} = 5'h00;
	// free running at clk/4 so every edge survives the synchroniser
	always @(posedge clk) begin
		ph <= ~ph;
		if (ph)
			mosc_tick <= ~mosc_tick;
	end
	task go_sleep(input deep);
		deep_sleep_en <= deep;
		@(posedge clk);
		wfi_req <= 1'b1;
		@(posedge clk);
		wfi_req <= 1'b0;
	endtask
	// early access mimics firmware without the wake-up delay loop
	task wake(input early);
		wake_irq <= 1'b1;
		@(posedge clk);
		wake_irq <= 1'b0;
		deep_sleep_en <= 1'b0;
		repeat (early ? 0 : 16) @(posedge clk);
		periph_access <= 1'b1;
		repeat (3) @(posedge clk);
		periph_access <= 1'b0;
		@(posedge clk);
	endtask
endmodule // pcg_core_model

// file: testbench/tb_pll_lock_and_sleep_clock_gating.sv
/* tb_pll_lock_and_sleep_clock_gating.sv: self-checking bench for pcg_clock_ctrl.
 Assumes pcg_core_model as the core side; this module is the APB master. */
`timescale 1ns/10ps
`include "pcg_consts.vh"
module tb_pll_lock_and_sleep_clock_gating;
	localparam [31:0] CFG_ON = 32'h0780_12d1;
	localparam [31:0] CFG_X = 32'h0780_1311;
	localparam integer RC = 4 * `PCG_RELOCK_COUNT;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg debug_enable_req = 1'b0;
	reg fault_seen = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0000_0000;
	reg [31:0] g, s, d, q;
	reg e;
	integer err_total = 0;
	integer total_checks = 0;
	integer n;
	wire [31:0] prdata, periph_clk_en;
	wire [5:0] sys_div;
	wire [1:0] sys_osc_sel;
	wire [2:0] int_osc_on;
	wire pready, pslverr, mosc_tick, wfi_req, deep_sleep_en, wake_irq, periph_access;
	wire pll_power_down, pll_lock_irq, use_pll, main_osc_off, core_clk_en, debug_enabled, hard_fault;
	pcg_core_model core (.clk(clk), .mosc_tick(mosc_tick), .wfi_req(wfi_req), .deep_sleep_en(deep_sleep_en),
		.wake_irq(wake_irq), .periph_access(periph_access));
	pcg_clock_ctrl uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mosc_tick(mosc_tick),
		.wfi_req(wfi_req), .deep_sleep_en(deep_sleep_en), .wake_irq(wake_irq), .debug_enable_req(debug_enable_req),
		.periph_access(periph_access), .pll_power_down(pll_power_down), .pll_lock_irq(pll_lock_irq),
		.use_pll(use_pll), .sys_osc_sel(sys_osc_sel), .sys_div(sys_div), .main_osc_off(main_osc_off),
		.int_osc_on(int_osc_on),
		.core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .debug_enabled(debug_enabled),
		.hard_fault(hard_fault));
	initial forever #4 clk = ~clk;
	always @(posedge clk) if (hard_fault === 1'b1) fault_seen <= 1'b1;
	task chk(input [31:0] got, input [31:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// idle cycle after each transfer so no strobe is driven twice in one step
	task apb(input wr, input [11:0] a, input [31:0] dat);
		integer k;
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, dat};
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k = k + 1;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		e = pslverr;
		if (k >= 20) begin
			chk(0, 1);
			results;
		end
		{psel, penable} <= 2'b00;
		@(posedge clk);
	endtask
	task rd(input [11:0] a, input [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask
	task wait_lock(input integer extra);
		n = 0;
		while (use_pll !== 1'b1 && n < RC + 100) begin
			@(posedge clk);
			n = n + 1;
		end
		chk(n + extra >= RC - 4 && n + extra <= RC + 8, 1);
		if (n >= RC + 100)
			results;
	endtask
	initial begin
		g = $urandom(11515);
		g = $urandom;
		s = $urandom;
		d = $urandom;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		chk({pll_power_down, use_pll, debug_enabled}, 3'h4);
		rd(`PCG_OFF_RUN_CFG, `PCG_RST_RUN_CFG);
		rd(`PCG_OFF_RUN_CFG_EXT, `PCG_RST_RUN_CFG_EXT);
		rd(`PCG_OFF_SLEEP_GATE, `PCG_RST_GATE);
		rd(`PCG_OFF_DEEP_CLK, `PCG_RST_DEEP_CLK);
		apb(1'b0, 12'h0fc, 32'h0000_0000);
		chk(e, 1);
		$display("test reset done");
		apb(1'b1, `PCG_OFF_RUN_GATE, g);
		apb(1'b1, `PCG_OFF_SLEEP_GATE, s);
		apb(1'b1, `PCG_OFF_DEEP_GATE, d);
		apb(1'b1, `PCG_OFF_MASK, 32'h0000_0040);
		apb(1'b1, `PCG_OFF_RUN_CFG, CFG_ON);
		repeat (2) @(posedge clk);
		chk({pll_power_down, use_pll}, 2'b00);
		chk(periph_clk_en, g);
		repeat (1000) @(posedge clk);
		apb(1'b1, `PCG_OFF_RUN_CFG, CFG_ON);
		wait_lock(1006);
		chk(pll_lock_irq, 1);
		rd(`PCG_OFF_RAW_STATUS, 32'h0000_0040);
		apb(1'b1, `PCG_OFF_MASKED, 32'h0000_0040);
		// the interrupt output follows the cleared flag one edge later
		@(posedge clk);
		chk(pll_lock_irq, 0);
		apb(1'b1, `PCG_OFF_RUN_CFG, CFG_X);
		@(posedge clk);
		chk(use_pll, 0);
		repeat (500) @(posedge clk);
		apb(1'b1, `PCG_OFF_RUN_CFG, CFG_ON);
		rd(`PCG_OFF_RAW_STATUS, 32'h0000_0000);
		wait_lock(4);
		$display("test relock done");
		core.go_sleep(1'b0);
		repeat (3) @(posedge clk);
		chk({core_clk_en, use_pll, sys_div}, {2'b01, 6'h0f});
		chk(sys_osc_sel, 2'b01);
		chk(periph_clk_en, g);
		core.wake(1'b0);
		chk(core_clk_en, 1);
		apb(1'b1, `PCG_OFF_RUN_CFG, CFG_ON | 32'h0800_0000);
		core.go_sleep(1'b0);
		repeat (3) @(posedge clk);
		chk(periph_clk_en, s);
		core.wake(1'b0);
		apb(1'b1, `PCG_OFF_DEEP_CLK, 32'h0280_0010);
		debug_enable_req <= 1'b1;
		@(posedge clk);
		debug_enable_req <= 1'b0;
		@(posedge clk);
		chk(debug_enabled, 1);
		core.go_sleep(1'b1);
		repeat (4) @(posedge clk);
		chk(periph_clk_en, d);
		chk({pll_power_down, use_pll, sys_div, main_osc_off}, {2'b10, 6'h05, 1'b1});
		chk({sys_osc_sel, int_osc_on}, {2'b00, 3'b001});
		core.wake(1'b1);
		chk(fault_seen, 1);
		repeat (16) @(posedge clk);
		chk({core_clk_en, sys_osc_sel, sys_div, use_pll}, {1'b1, 2'b01, 6'h0f, 1'b0});
		// the pll was powered down in deep sleep, so it comes back only after a full relock
		wait_lock(20);
		$display("test modes done");
		results;
	end
endmodule // tb_pll_lock_and_sleep_clock_gating
